// >>> logic/mie_alu.sv
// Combinational result unit for increment, move, OR and rotates
`timescale 1ns/1ps
module mie_alu import mie_pkg::*; #(
  parameter int W = DW
) (
  // Operation select
  input wire logic [OPC_W-1:0] opcode,
  // Operands
  input wire logic [W-1:0] acc,
  input wire logic [W-1:0] mem,
  input wire logic [W-1:0] imm,
  input wire logic carry_in,
  // Results
  output logic [W-1:0] result,
  output logic carry_out,
  output logic zero
);

  // Result and carry per opcode
  always_comb begin
    result = mem;
    carry_out = carry_in;
    case (opcode)
      OP_INCREMENT, OP_INCREMENT_TO_ACCUMULATOR: begin
        result = mem + W'(BYTE_ONE); // see [RULE4]
      end
      OP_MOVE_MEM_TO_ACC: begin
        result = mem; // see [RULE7]
      end
      OP_MOVE_ACC_TO_MEM: begin
        result = acc; // see [RULE7]
      end
      OP_MOVE_IMM_TO_ACC, OP_RETURN_WITH_VALUE: begin
        result = imm; // see [RULE6] see [RULE12]
      end
      OP_OR_MEM, OP_OR_INTO_MEMORY: begin
        result = acc | mem; // see [RULE9] see [RULE10]
      end
      OP_OR_IMM: begin
        result = acc | imm; // see [RULE9]
      end
      OP_ROTATE_LEFT, OP_ROTATE_LEFT_TO_ACCUMULATOR: begin
        result = {mem[W-2:0], mem[W-1]}; // see [RULE14] see [RULE15]
      end
      OP_ROTATE_LEFT_THROUGH_CARRY,
      OP_ROTATE_LEFT_CARRY_TO_ACCUMULATOR: begin
        result = {mem[W-2:0], carry_in}; // see [RULE16] see [RULE17]
        carry_out = mem[W-1];
      end
      OP_ROTATE_RIGHT, OP_ROTATE_RIGHT_TO_ACCUMULATOR: begin
        result = {mem[0], mem[W-1:1]}; // see [RULE18] see [RULE19]
      end
      OP_ROTATE_RIGHT_THROUGH_CARRY, OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
        result = {carry_in, mem[W-1:1]}; // see [RULE20]
        carry_out = mem[0];
      end
      default: begin
        result = mem;
        carry_out = carry_in;
      end
    endcase
  end

  // Zero detect on the full result
  assign zero = (result == W'(BYTE_ZERO)); // see [RULE21]

endmodule

// >>> logic/mie_core.sv
// Instruction execute core: sequencer, registers, flags and memory ports
`timescale 1ns/1ps
// Overview of operation
// [RULE1] Power down keeps RAM and registers, clears watchdog and prescaler.
// [RULE2] Power down: PC plus one, power-down flag set, timeout flag cleared.
// [RULE3] Power down halts execution and switches the system clock off.
// [RULE4] Increment adds one to the byte; to memory or accumulator; zero flag.
// [RULE5] Direct jump loads the coded address into PC; no flag changes.
// [RULE6] Move immediate loads the 8-bit constant into the accumulator.
// [RULE7] Register moves copy byte to accumulator or back; no flags.
// [RULE8] No-operation only advances PC by one.
// [RULE9] OR of accumulator with byte or constant into accumulator; zero flag.
// [RULE10] OR into memory writes the OR result back; zero flag only.
// [RULE11] Return pops PC, takes two instruction cycles, keeps flags.
// [RULE12] Return with value pops PC and loads the constant into accumulator.
// [RULE13] Interrupt return pops PC and sets the global interrupt enable.
// [RULE14] Left rotate: bit 7 into bit 0, written back; no flags.
// [RULE15] Accumulator left rotate: result to accumulator, memory unchanged.
// [RULE16] Left rotate through carry: old carry in, old bit 7 to carry.
// [RULE17] Accumulator form of that: accumulator only, carry still updated.
// [RULE18] Right rotate: bit 0 into bit 7, written back; no flags.
// [RULE19] Accumulator right rotate: result to accumulator, memory unchanged.
// [RULE20] Right rotate through carry: old carry to bit 7, bit 0 to carry.
// [RULE21] Zero flag is set for an all-zero result, else cleared.
module mie_core import mie_pkg::*; #(
  parameter int DEPTH = STACK_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Program memory
  output logic [PC_W-1:0] pm_addr_q,
  input wire logic [IW-1:0] pm_rdata,
  // Data memory
  output logic [DM_AW-1:0] dm_addr_q,
  output logic [DW-1:0] dm_wdata_q,
  output logic dm_we_q,
  input wire logic [DW-1:0] dm_rdata,
  // Stack push from call and interrupt logic
  input wire logic stack_push,
  input wire logic [PC_W-1:0] stack_push_addr,
  // Watchdog and power
  input wire logic watchdog_timeout,
  input wire logic flag_clear,
  input wire logic wake_up,
  output logic wdt_clear_q,
  output logic sys_clk_en_q,
  // Interrupt control
  input wire logic irq_enable_clear,
  output logic global_irq_enable_q,
  // Architectural state
  output logic [DW-1:0] acc_q,
  output logic zero_q,
  output logic carry_q,
  output logic power_down_flag_q,
  output logic watchdog_timeout_flag_q,
  output logic instr_end_q
);

  // ****************************************
  // Declarations
  // ****************************************
  mie_state_t state_q;
  logic [IW-1:0] instr_q;
  logic [OPC_W-1:0] op;
  logic exec;
  logic is_jump;
  logic wr_acc;
  logic wr_mem;
  logic upd_z;
  logic upd_c;
  logic do_pop;
  logic do_halt;
  logic do_return_from_interrupt;
  logic [DW-1:0] alu_res;
  logic alu_carry;
  logic alu_zero;
  logic [PC_W-1:0] stack_top;

  assign op = instr_q[OPC_HI:OPC_LO];
  assign exec = (state_q == MIE_S_EXEC);
  assign is_jump = (instr_q[TAG_HI:TAG_LO] == JUMP_TAG);

  // ****************************************
  // Decode
  // ****************************************

  // Destination and flag enables per opcode
  always_comb begin
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    upd_z = 1'b0;
    upd_c = 1'b0;
    do_pop = 1'b0;
    do_halt = 1'b0;
    do_return_from_interrupt = 1'b0;
    if (!is_jump) begin
      case (op)
        OP_POWER_DOWN: begin
          do_halt = 1'b1; // see [RULE1]
        end
        OP_RETURN: begin
          do_pop = 1'b1; // see [RULE11]
        end
        OP_RETURN_FROM_INTERRUPT: begin
          do_pop = 1'b1; // see [RULE13]
          do_return_from_interrupt = 1'b1;
        end
        OP_RETURN_WITH_VALUE: begin
          do_pop = 1'b1; // see [RULE12]
          wr_acc = 1'b1;
        end
        OP_INCREMENT, OP_OR_INTO_MEMORY: begin
          wr_mem = 1'b1; // see [RULE4] see [RULE10]
          upd_z = 1'b1;
        end
        OP_INCREMENT_TO_ACCUMULATOR, OP_OR_MEM, OP_OR_IMM: begin
          wr_acc = 1'b1; // see [RULE4] see [RULE9]
          upd_z = 1'b1;
        end
        OP_MOVE_MEM_TO_ACC, OP_MOVE_IMM_TO_ACC: begin
          wr_acc = 1'b1; // see [RULE6] see [RULE7]
        end
        OP_MOVE_ACC_TO_MEM, OP_ROTATE_LEFT, OP_ROTATE_RIGHT: begin
          wr_mem = 1'b1; // see [RULE7] see [RULE14] see [RULE18]
        end
        OP_ROTATE_LEFT_TO_ACCUMULATOR,
        OP_ROTATE_RIGHT_TO_ACCUMULATOR: begin
          wr_acc = 1'b1; // see [RULE15] see [RULE19]
        end
        OP_ROTATE_LEFT_THROUGH_CARRY,
        OP_ROTATE_RIGHT_THROUGH_CARRY: begin
          wr_mem = 1'b1; // see [RULE16] see [RULE20]
          upd_c = 1'b1;
        end
        OP_ROTATE_LEFT_CARRY_TO_ACCUMULATOR,
        OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
          wr_acc = 1'b1; // see [RULE17]
          upd_c = 1'b1;
        end
        default: begin
          wr_acc = 1'b0; // No-operation and unused codes
        end
      endcase
    end
  end

  // ****************************************
  // Datapath and stack
  // ****************************************
  mie_alu #(
    .W(DW)
  ) u_alu (
    .opcode(op),
    .acc(acc_q),
    .mem(dm_rdata),
    .imm(instr_q[OPERAND_HI:OPERAND_LO]),
    .carry_in(carry_q),
    .result(alu_res),
    .carry_out(alu_carry),
    .zero(alu_zero)
  );

  mie_stack #(
    .DEPTH(DEPTH),
    .W(PC_W)
  ) u_stack (
    .clk(clk),
    .rst_n(rst_n),
    .push(stack_push),
    .push_data(stack_push_addr),
    .pop(exec && do_pop),
    .top(stack_top)
  );

  // ****************************************
  // Sequencer
  // ****************************************

  // Fetch, execute, two dummy clocks for returns, halt
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= MIE_S_FETCH;
    end else begin
      case (state_q)
        MIE_S_FETCH: begin
          state_q <= MIE_S_EXEC;
        end
        MIE_S_EXEC: begin
          if (do_halt) begin
            state_q <= MIE_S_HALT; // see [RULE3]
          end else if (do_pop) begin
            state_q <= MIE_S_DUMMY1; // see [RULE11]
          end else begin
            state_q <= MIE_S_FETCH;
          end
        end
        MIE_S_DUMMY1: begin
          state_q <= MIE_S_DUMMY2;
        end
        MIE_S_DUMMY2: begin
          state_q <= MIE_S_FETCH;
        end
        MIE_S_HALT: begin
          if (wake_up) begin
            state_q <= MIE_S_FETCH;
          end
        end
        default: begin
          state_q <= MIE_S_FETCH;
        end
      endcase
    end
  end

  // Instruction latch and data address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_q <= INSTR_RST;
      dm_addr_q <= DM_ADDR_RST;
    end else if (state_q == MIE_S_FETCH) begin
      instr_q <= pm_rdata;
      dm_addr_q <= pm_rdata[OPERAND_HI:OPERAND_LO];
    end
  end

  // Program counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pm_addr_q <= PC_RST;
    end else if (exec) begin
      if (is_jump) begin
        pm_addr_q <= instr_q[TARGET_HI:TARGET_LO]; // see [RULE5]
      end else if (do_pop) begin
        pm_addr_q <= stack_top; // see [RULE11] see [RULE12] see [RULE13]
      end else begin
        pm_addr_q <= pm_addr_q + PC_STEP; // see [RULE2] see [RULE8]
      end
    end
  end

  // Instruction completion pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_end_q <= 1'b0;
    end else begin
      instr_end_q <= (exec && !do_pop) || (state_q == MIE_S_DUMMY2);
    end
  end

  // ****************************************
  // Registers and memory write
  // ****************************************

  // Accumulator
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= ACC_RST;
    end else if (exec && wr_acc) begin
      acc_q <= alu_res; // see [RULE15] see [RULE17] see [RULE19]
    end
  end

  // Data memory write, one clock pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dm_we_q <= 1'b0;
      dm_wdata_q <= BYTE_ZERO;
    end else begin
      dm_we_q <= exec && wr_mem; // see [RULE10] see [RULE14]
      if (exec && wr_mem) begin
        dm_wdata_q <= alu_res;
      end
    end
  end

  // Zero and carry flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      zero_q <= 1'b0;
      carry_q <= 1'b0;
    end else if (exec) begin
      if (upd_z) begin
        zero_q <= alu_zero; // see [RULE21]
      end
      if (upd_c) begin
        carry_q <= alu_carry; // see [RULE16] see [RULE20]
      end
    end
  end

  // Power-down and timeout flags; hardware set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_down_flag_q <= 1'b0;
      watchdog_timeout_flag_q <= 1'b0;
    end else begin
      if (exec && do_halt) begin
        power_down_flag_q <= 1'b1; // see [RULE2]
      end else if (flag_clear) begin
        power_down_flag_q <= 1'b0;
      end
      if (watchdog_timeout) begin
        watchdog_timeout_flag_q <= 1'b1;
      end else if ((exec && do_halt) || flag_clear) begin
        watchdog_timeout_flag_q <= 1'b0; // see [RULE2]
      end
    end
  end

  // Watchdog clear pulse and system clock enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_clear_q <= 1'b0;
      sys_clk_en_q <= 1'b1;
    end else begin
      wdt_clear_q <= exec && do_halt; // see [RULE1]
      if (exec && do_halt) begin
        sys_clk_en_q <= 1'b0; // see [RULE3]
      end else if (state_q == MIE_S_HALT && wake_up) begin
        sys_clk_en_q <= 1'b1;
      end
    end
  end

  // Global interrupt enable; return set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      global_irq_enable_q <= 1'b0;
    end else if (exec && do_return_from_interrupt) begin
      global_irq_enable_q <= 1'b1; // see [RULE13]
    end else if (irq_enable_clear) begin
      global_irq_enable_q <= 1'b0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_HALT_FLAGS: assert property ( // see [RULE2]
    exec && do_halt && !watchdog_timeout |=> power_down_flag_q
      && !watchdog_timeout_flag_q && pm_addr_q == $past(pm_addr_q) + PC_STEP)
    else $error("power down flags or PC wrong");

  AST_HALT_STOP: assert property ( // see [RULE3]
    exec && do_halt && !wake_up |=> wdt_clear_q && !sys_clk_en_q
      ##1 !wdt_clear_q && state_q == MIE_S_HALT)
    else $error("power down did not stop the core");

  AST_HALT_NO_WRITE: assert property ( // see [RULE1]
    exec && do_halt |=> !dm_we_q && $stable(acc_q) && $stable(carry_q))
    else $error("power down changed state");

  AST_JUMP_TARGET: assert property ( // see [RULE5]
    exec && is_jump |=> pm_addr_q == $past(instr_q[TARGET_HI:TARGET_LO])
      && $stable(zero_q) && $stable(carry_q))
    else $error("jump target not loaded");

  AST_NOP_QUIET: assert property ( // see [RULE8]
    exec && !is_jump && op == OP_NOP |=> !dm_we_q && $stable(acc_q)
      && $stable(zero_q) && pm_addr_q == $past(pm_addr_q) + PC_STEP)
    else $error("no-operation changed state");

  AST_RETURN_TWO: assert property ( // see [RULE11]
    exec && do_pop |=> state_q == MIE_S_DUMMY1 ##1 state_q == MIE_S_DUMMY2
      ##1 state_q == MIE_S_FETCH && instr_end_q)
    else $error("return did not take two instruction cycles");

  AST_RETURN_PC: assert property ( // see [RULE12]
    exec && do_pop |=> pm_addr_q == $past(stack_top) && $stable(zero_q))
    else $error("return did not restore PC");

  AST_RETURN_FROM_INTERRUPT_ENABLE: assert property ( // see [RULE13]
    exec && do_return_from_interrupt |=> global_irq_enable_q)
    else $error("interrupt return left interrupts off");

  AST_ZERO_FLAG: assert property ( // see [RULE21]
    exec && upd_z |=> zero_q == ($past(alu_res) == BYTE_ZERO))
    else $error("zero flag mismatch");

  AST_CARRY_LEFT: assert property ( // see [RULE16]
    exec && !is_jump && op == OP_ROTATE_LEFT_THROUGH_CARRY
      |=> carry_q == $past(dm_rdata[DW-1]) && dm_we_q
      && dm_wdata_q[0] == $past(carry_q))
    else $error("left rotate through carry wrong");

  AST_ACC_FORM: assert property ( // see [RULE15]
    exec && wr_acc |=> !dm_we_q && acc_q == $past(alu_res))
    else $error("accumulator form touched memory");

endmodule

// >>> logic/mie_pkg.sv
// Constants, opcodes and state codes for the instruction execute core
package mie_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int PC_W = 11;
  localparam int DW = 8;
  localparam int IW = 14;
  localparam int OPC_W = 6;
  localparam int DM_AW = 8;
  localparam int STACK_DEPTH = 6;

  // ****************************************
  // Instruction word fields
  // ****************************************
  localparam int OPC_HI = 13;
  localparam int OPC_LO = 8;
  localparam int TAG_HI = 13;
  localparam int TAG_LO = 11;
  localparam int OPERAND_HI = 7;
  localparam int OPERAND_LO = 0;
  localparam int TARGET_HI = 10;
  localparam int TARGET_LO = 0;
  localparam logic [2:0] JUMP_TAG = 3'h7;

  // ****************************************
  // Opcodes, instruction bits 13..8
  // ****************************************
  localparam logic [OPC_W-1:0] OP_NOP = 6'h00;
  localparam logic [OPC_W-1:0] OP_POWER_DOWN = 6'h01;
  localparam logic [OPC_W-1:0] OP_RETURN = 6'h02;
  localparam logic [OPC_W-1:0] OP_RETURN_FROM_INTERRUPT = 6'h03;
  localparam logic [OPC_W-1:0] OP_INCREMENT = 6'h10;
  localparam logic [OPC_W-1:0] OP_INCREMENT_TO_ACCUMULATOR = 6'h11;
  localparam logic [OPC_W-1:0] OP_MOVE_MEM_TO_ACC = 6'h12;
  localparam logic [OPC_W-1:0] OP_MOVE_ACC_TO_MEM = 6'h13;
  localparam logic [OPC_W-1:0] OP_MOVE_IMM_TO_ACC = 6'h14;
  localparam logic [OPC_W-1:0] OP_RETURN_WITH_VALUE = 6'h15;
  localparam logic [OPC_W-1:0] OP_OR_MEM = 6'h16;
  localparam logic [OPC_W-1:0] OP_OR_IMM = 6'h17;
  localparam logic [OPC_W-1:0] OP_OR_INTO_MEMORY = 6'h18;
  localparam logic [OPC_W-1:0] OP_ROTATE_LEFT = 6'h19;
  localparam logic [OPC_W-1:0] OP_ROTATE_LEFT_TO_ACCUMULATOR = 6'h1a;
  localparam logic [OPC_W-1:0] OP_ROTATE_LEFT_THROUGH_CARRY = 6'h1b;
  localparam logic [OPC_W-1:0] OP_ROTATE_LEFT_CARRY_TO_ACCUMULATOR = 6'h1c;
  localparam logic [OPC_W-1:0] OP_ROTATE_RIGHT = 6'h1d;
  localparam logic [OPC_W-1:0] OP_ROTATE_RIGHT_TO_ACCUMULATOR = 6'h1e;
  localparam logic [OPC_W-1:0] OP_ROTATE_RIGHT_THROUGH_CARRY = 6'h1f;
  localparam logic [OPC_W-1:0] OP_ROTATE_RIGHT_CARRY_TO_ACC = 6'h20;

  // ****************************************
  // Reset values and constants
  // ****************************************
  localparam logic [PC_W-1:0] PC_RST = 11'h000;
  localparam logic [DW-1:0] ACC_RST = 8'h00;
  localparam logic [DM_AW-1:0] DM_ADDR_RST = 8'h00;
  localparam logic [IW-1:0] INSTR_RST = 14'h0000;
  localparam logic [PC_W-1:0] PC_STEP = 11'h001;
  localparam logic [DW-1:0] BYTE_ONE = 8'h01;
  localparam logic [DW-1:0] BYTE_ZERO = 8'h00;

  // ****************************************
  // Sequencer states, one-hot
  // ****************************************
  typedef enum logic [4:0] {
    MIE_S_FETCH = 5'h01,
    MIE_S_EXEC = 5'h02,
    MIE_S_DUMMY1 = 5'h04,
    MIE_S_DUMMY2 = 5'h08,
    MIE_S_HALT = 5'h10
  } mie_state_t;

endpackage

// >>> logic/mie_stack.sv
// Circular hardware return-address stack
`timescale 1ns/1ps
module mie_stack #(
  parameter int DEPTH = 6,
  parameter int W = 11
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Push and pop
  input wire logic push,
  input wire logic [W-1:0] push_data,
  input wire logic pop,
  // Top entry
  output logic [W-1:0] top
);

  localparam int PW = $clog2(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] ptr_q;
  logic [PW-1:0] prev;

  // Index of the newest entry
  assign prev = (ptr_q == '0) ? LAST : ptr_q - PW'(1);
  assign top = mem[prev];

  // Pointer wraps; overflow overwrites the oldest entry
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= '0;
    end else if (push) begin
      ptr_q <= (ptr_q == LAST) ? '0 : ptr_q + PW'(1);
    end else if (pop) begin
      ptr_q <= prev;
    end
  end

  // Entry storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[ptr_q] <= push_data;
    end
  end

endmodule

// >>> verif/mie_core_tb_top.sv
// Self-checking bench running a short program through the execute core
`timescale 1ns/1ps
module mie_core_tb_top import mie_pkg::*;;
  logic clk, rst_n, dm_we_q, stack_push, watchdog_timeout, flag_clear;
  logic wake_up, wdt_clear_q, sys_clk_en_q, irq_enable_clear;
  logic global_irq_enable_q, zero_q, carry_q, power_down_flag_q;
  logic watchdog_timeout_flag_q, instr_end_q, wdt_seen;
  logic [PC_W-1:0] pm_addr_q, stack_push_addr, pa;
  logic [IW-1:0] pm_rdata;
  logic [DM_AW-1:0] dm_addr_q;
  logic [DW-1:0] dm_wdata_q, dm_rdata, acc_q;
  int errors, num_checks, gap;

  mie_core u_dut (.clk, .rst_n, .pm_addr_q, .pm_rdata, .dm_addr_q,
    .dm_wdata_q, .dm_we_q, .dm_rdata, .stack_push, .stack_push_addr,
    .watchdog_timeout, .flag_clear, .wake_up, .wdt_clear_q, .sys_clk_en_q,
    .irq_enable_clear, .global_irq_enable_q, .acc_q, .zero_q, .carry_q,
    .power_down_flag_q, .watchdog_timeout_flag_q, .instr_end_q);

  mie_mem_model u_mem (.clk, .pm_addr_q, .pm_rdata, .dm_addr_q,
    .dm_wdata_q, .dm_we_q, .dm_rdata);

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Remembers any watchdog clear pulse
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_seen <= 1'b0;
    end else if (wdt_clear_q) begin
      wdt_seen <= 1'b1;
    end
  end

  // Verdict and end of run
  task automatic test_done();
    if (errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Compare and report
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Writes one instruction word into the ROM
  task automatic put(logic [OPC_W-1:0] op, logic [DW-1:0] v);
    u_mem.prog_mem[pa] = {op, v};
    pa++;
  endtask

  // Waits for an instruction to end with PC at pc, then checks state
  task automatic exe(logic [PC_W-1:0] pc, logic [DW-1:0] a,
                     logic [1:0] zc);
    gap = 0;
    do begin
      @(posedge clk);
      #1;
      gap++;
      if (gap > 40) begin
        errors++;
        test_done();
      end
    end while (!(instr_end_q === 1'b1 && pm_addr_q === pc));
    chk("acc", acc_q, a);
    chk("zero_carry", {zero_q, carry_q}, zc);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    stack_push = 1'b0;
    stack_push_addr = PC_RST;
    watchdog_timeout = 1'b0;
    flag_clear = 1'b0;
    wake_up = 1'b0;
    irq_enable_clear = 1'b0;
    errors = 0;
    num_checks = 0;
    pa = PC_RST;
    @(posedge clk);
    u_mem.data_mem[12] = 8'hff;
    repeat (6) put(OP_NOP, 8'h00);
    put(OP_MOVE_IMM_TO_ACC, 8'h81);
    put(OP_MOVE_ACC_TO_MEM, 8'h0a);
    put(OP_ROTATE_LEFT, 8'h0a);
    put(OP_ROTATE_LEFT_TO_ACCUMULATOR, 8'h0a);
    put(OP_MOVE_IMM_TO_ACC, 8'h80);
    put(OP_MOVE_ACC_TO_MEM, 8'h0b);
    put(OP_ROTATE_LEFT_THROUGH_CARRY, 8'h0b);
    put(OP_ROTATE_LEFT_CARRY_TO_ACCUMULATOR, 8'h0b);
    put(OP_ROTATE_RIGHT, 8'h0a);
    put(OP_ROTATE_RIGHT_TO_ACCUMULATOR, 8'h0a);
    put(OP_ROTATE_RIGHT_THROUGH_CARRY, 8'h0a);
    put(OP_ROTATE_RIGHT_CARRY_TO_ACC, 8'h0a);
    put(OP_INCREMENT, 8'h0c);
    put(OP_INCREMENT_TO_ACCUMULATOR, 8'h0a);
    put(OP_MOVE_IMM_TO_ACC, 8'h00);
    put(OP_OR_IMM, 8'h00);
    put(OP_OR_MEM, 8'h0a);
    put(OP_OR_INTO_MEMORY, 8'h0b);
    put(OP_MOVE_MEM_TO_ACC, 8'h0c);
    put(OP_NOP, 8'h00);
    u_mem.prog_mem[pa] = {JUMP_TAG, 11'h100};
    pa = 11'h100;
    put(OP_RETURN_WITH_VALUE, 8'h5a);
    pa = 11'h200;
    put(OP_RETURN, 8'h00);
    pa = 11'h300;
    put(OP_RETURN_FROM_INTERRUPT, 8'h00);
    pa = 11'h400;
    put(OP_POWER_DOWN, 8'h00);
    put(OP_MOVE_IMM_TO_ACC, 8'h33);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // Return addresses pushed while the leading no-ops run
    for (int i = 4; i > 1; i--) begin
      @(posedge clk);
      stack_push <= 1'b1;
      stack_push_addr <= PC_W'(i * 256);
      watchdog_timeout <= (i == 4);
    end
    @(posedge clk);
    stack_push <= 1'b0;
    exe(11'h007, 8'h81, 2'h0);
    chk("timeout_flag", watchdog_timeout_flag_q, 1'h1);
    exe(11'h008, 8'h81, 2'h0);
    exe(11'h009, 8'h81, 2'h0);
    chk("ram", u_mem.data_mem[10], 8'h81);
    exe(11'h00a, 8'h06, 2'h0);
    chk("ram", u_mem.data_mem[10], 8'h03);
    exe(11'h00b, 8'h80, 2'h0);
    chk("ram", u_mem.data_mem[10], 8'h03);
    exe(11'h00c, 8'h80, 2'h0);
    exe(11'h00d, 8'h80, 2'h1);
    exe(11'h00e, 8'h01, 2'h0);
    chk("ram", u_mem.data_mem[11], 8'h00);
    exe(11'h00f, 8'h01, 2'h0);
    chk("ram", u_mem.data_mem[11], 8'h00);
    exe(11'h010, 8'hc0, 2'h0);
    chk("ram", u_mem.data_mem[10], 8'h81);
    exe(11'h011, 8'hc0, 2'h1);
    chk("ram", u_mem.data_mem[10], 8'h81);
    exe(11'h012, 8'ha0, 2'h0);
    chk("ram", u_mem.data_mem[10], 8'h40);
    exe(11'h013, 8'ha0, 2'h2);
    chk("ram", u_mem.data_mem[10], 8'h40);
    exe(11'h014, 8'h41, 2'h0);
    chk("ram", u_mem.data_mem[12], 8'h00);
    exe(11'h015, 8'h00, 2'h0);
    chk("ram", u_mem.data_mem[10], 8'h40);
    exe(11'h016, 8'h00, 2'h2);
    exe(11'h017, 8'h40, 2'h0);
    exe(11'h018, 8'h40, 2'h0);
    exe(11'h019, 8'h00, 2'h0);
    chk("ram", u_mem.data_mem[11], 8'h40);
    exe(11'h01a, 8'h00, 2'h0);
    chk("gap", 16'(gap), 16'h0002);
    exe(11'h100, 8'h00, 2'h0);
    exe(11'h200, 8'h5a, 2'h0);
    exe(11'h300, 8'h5a, 2'h0);
    chk("gap", 16'(gap), 16'h0004);
    chk("irq_en", global_irq_enable_q, 1'h0);
    exe(11'h400, 8'h5a, 2'h0);
    chk("irq_en", global_irq_enable_q, 1'h1);
    // Power down: wait for the clock gate to drop
    for (int i = 0; i < 10 && sys_clk_en_q !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    if (sys_clk_en_q !== 1'b0) begin
      errors++;
      test_done();
    end
    chk("pc", pm_addr_q, 11'h401);
    chk("power_down_flag", power_down_flag_q, 1'h1);
    chk("timeout_flag", watchdog_timeout_flag_q, 1'h0);
    chk("zero_carry", {zero_q, carry_q}, 2'h0);
    chk("acc", acc_q, 8'h5a);
    repeat (6) @(posedge clk);
    #1;
    chk("wdt_clear", wdt_seen, 1'h1);
    chk("ram", u_mem.data_mem[11], 8'h40);
    chk("halt", {sys_clk_en_q, pm_addr_q}, 12'h401);
    @(posedge clk);
    wake_up <= 1'b1;
    @(posedge clk);
    wake_up <= 1'b0;
    exe(11'h402, 8'h33, 2'h0);
    chk("clk_en", sys_clk_en_q, 1'h1);
    @(posedge clk);
    flag_clear <= 1'b1;
    irq_enable_clear <= 1'b1;
    @(posedge clk);
    flag_clear <= 1'b0;
    irq_enable_clear <= 1'b0;
    @(posedge clk);
    #1;
    chk("power_down_flag", power_down_flag_q, 1'h0);
    chk("irq_en", global_irq_enable_q, 1'h0);
    test_done();
  end
endmodule

// >>> verif/mie_mem_model.sv
// Program ROM and asynchronous data RAM facing the execute core
`timescale 1ns/1ps
module mie_mem_model import mie_pkg::*; (
  // Clock
  input wire logic clk,
  // Program memory
  input wire logic [PC_W-1:0] pm_addr_q,
  output logic [IW-1:0] pm_rdata,
  // Data memory
  input wire logic [DM_AW-1:0] dm_addr_q,
  input wire logic [DW-1:0] dm_wdata_q,
  input wire logic dm_we_q,
  output logic [DW-1:0] dm_rdata
);
  logic [IW-1:0] prog_mem [2**PC_W];
  logic [DW-1:0] data_mem [2**DM_AW];

  // Blank ROM reads as no-operation, RAM starts cleared
  initial begin
    for (int i = 0; i < 2**PC_W; i++) begin
      prog_mem[i] = INSTR_RST;
    end
    for (int i = 0; i < 2**DM_AW; i++) begin
      data_mem[i] = BYTE_ZERO;
    end
  end

  // Both reads are combinational from the address
  assign pm_rdata = prog_mem[pm_addr_q];
  assign dm_rdata = data_mem[dm_addr_q];

  // Write lands at the edge that ends the strobe cycle
  always @(posedge clk) begin
    if (dm_we_q) begin
      data_mem[dm_addr_q] <= dm_wdata_q;
    end
  end
endmodule
